/* rtl/oaf_pkg.sv */
// Constants, register map and state codes of the oversampling average filter
package oaf_pkg;

  // Channel and data geometry
  localparam int NUM_CH = 8;
  localparam int SAMPLE_W = 16;
  localparam int MAX_SHIFT = 6;
  localparam int ACC_W = SAMPLE_W + MAX_SHIFT;
  localparam int CNT_W = 7;

  // Clock and internal sample pacing (200 kSPS per channel without averaging)
  localparam int CLK_PERIOD_NS = 8;
  localparam int SAMPLE_PERIOD_NS = 5000;
  localparam int PACE_CYCLES = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PACE_W = 10;

  // Ratio select codes
  localparam logic [2:0] RATIO_NONE = 3'h0;
  localparam logic [2:0] RATIO_INVALID = 3'h7;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] BURSTS_OFS = 8'h08;
  localparam logic [7:0] RESULT_BASE_OFS = 8'h10;
  localparam logic [7:0] RESULT_LAST_OFS = 8'h2c;

  // Control register fields and reset values
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SOFT_START_BIT = 1;
  localparam logic CTRL_ENABLE_RESET = 1'b1;

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_INVALID_BIT = 1;
  localparam int STAT_SPAN_BIT = 2;
  localparam int STAT_OVERRUN_BIT = 3;
  localparam int STAT_FRESH_BIT = 4;
  localparam int STAT_RATIO_LSB = 8;

  // Burst sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_TRIG = 5'b00010,
    ST_CONV = 5'b00100,
    ST_PACE = 5'b01000,
    ST_DONE = 5'b10000
  } oaf_state_e;

endpackage

/* rtl/oaf_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module oaf_pin_sync
#(
  parameter int W = 1
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous pins and their settled levels
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] s1_r; // First stage, read only by s2_r
  logic [W-1:0] s2_r; // Second stage
  logic [W-1:0] s3_r; // Third stage

  // Shift chain
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit changes only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          level_o[i] <= 1'b0;
        else if (s2_r[i] == s3_r[i])
          level_o[i] <= s3_r[i];
      end
    end
  endgenerate

endmodule // oaf_pin_sync

`default_nettype wire

/* rtl/oaf_filter.sv */
// Oversampling average filter: burst sequencer, accumulators, Wishbone registers
// How it works
// - Ratio comes from the static three-bit select pins
// - 000 none, 001-110 ratios 2..64, 111 invalid
// - Output rate falls as one over ratio
// - First sample on start rising edge
// - Later samples paced internally, no host edges
// - Sum each channel's burst and average it
// - One 16-bit word per channel per burst
// - One span select sets all eight channels
// - Results are 16-bit two's complement always
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module oaf_filter
  import oaf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host configuration and start pins
  input wire logic sample_start_a_i,
  input wire logic sample_start_b_i,
  input wire logic [2:0] average_ratio_select_i,
  input wire logic span_select_i,
  // Converter core
  output logic conv_trigger_o,
  input wire logic conv_done_i,
  input wire logic [NUM_CH*SAMPLE_W-1:0] conv_data_i,
  // Front end and result stream
  output logic span_10v_o,
  output logic [NUM_CH*SAMPLE_W-1:0] result_o,
  output logic result_valid_o,
  output logic busy_o
);

  // Settled pin levels
  logic [5:0] pins_sync; // Synchronised pins
  logic start_a; // Start A level
  logic start_b; // Start B level
  logic [2:0] ratio_pin; // Ratio select level
  logic span_pin; // Span select level

  // Sequencer state
  oaf_state_e state_r; // Burst state
  logic start_both_r; // Previous AND of both starts
  logic start_edge; // Rising edge of both starts
  logic start_req; // Burst request from pins or software
  logic [2:0] shift_r; // Log2 of ratio for this burst
  logic [CNT_W-1:0] total_r; // Samples in this burst
  logic [CNT_W-1:0] taken_r; // Samples converted so far
  logic [PACE_W-1:0] pace_r; // Pacing divider
  logic pace_tick; // Pacing enable, held high while the divider sits saturated at its last count

  // Accumulators and results
  logic signed [ACC_W-1:0] acc_r [NUM_CH]; // Per-channel running sums

  // Registers
  logic enable_r; // Filter enable from software
  logic soft_start_r; // Software start pulse
  logic overrun_r; // Start seen while busy
  logic fresh_r; // New results not yet read
  logic [15:0] bursts_r; // Completed burst count
  logic bus_req; // Bus cycle needing answer
  logic wr_en; // Write strobe this cycle
  logic rd_fresh_clr; // Read of a result word
  logic [31:0] rd_data; // Read mux output
  logic [2:0] res_word; // Channel of a result word address

  // Pin synchroniser
  oaf_pin_sync #(
    .W(6)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({span_select_i, average_ratio_select_i, sample_start_b_i, sample_start_a_i}),
    .level_o(pins_sync)
  );

  assign start_a = pins_sync[0];
  assign start_b = pins_sync[1];
  assign ratio_pin = pins_sync[4:2];
  assign span_pin = pins_sync[5];

  // Span drive, one level for every channel
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      span_10v_o <= 1'b0;
    else
      span_10v_o <= span_pin;
  end

  // Edge detect on both start pins together
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      start_both_r <= 1'b0;
    else
      start_both_r <= start_a & start_b;
  end

  assign start_edge = start_a & start_b & ~start_both_r;
  assign start_req = enable_r & (start_edge | soft_start_r);

  // Pacing divider, restarted at every trigger
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pace_r <= '0;
    else if (state_r == ST_TRIG)
      pace_r <= '0;
    else if (pace_r != PACE_W'(PACE_CYCLES - 1))
      pace_r <= pace_r + PACE_W'(1);
  end

  assign pace_tick = (pace_r == PACE_W'(PACE_CYCLES - 1));

  // Burst sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (start_req)
            state_r <= ST_TRIG;
        end
        ST_TRIG:
          state_r <= ST_CONV;
        ST_CONV:
        begin
          // Last sample goes to averaging, else wait for pacing
          if (conv_done_i)
            state_r <= (taken_r + CNT_W'(1) == total_r) ? ST_DONE : ST_PACE;
        end
        ST_PACE:
        begin
          if (pace_tick)
            state_r <= ST_TRIG;
        end
        ST_DONE:
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Ratio latched at burst start; invalid code falls back to no averaging
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shift_r <= RATIO_NONE;
      total_r <= CNT_W'(1);
    end
    else if (state_r == ST_IDLE && start_req)
    begin
      if (ratio_pin == RATIO_INVALID)
      begin
        shift_r <= RATIO_NONE;
        total_r <= CNT_W'(1);
      end
      else
      begin
        shift_r <= ratio_pin;
        total_r <= CNT_W'(1) << ratio_pin;
      end
    end
  end

  // Sample counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      taken_r <= '0;
    else if (state_r == ST_IDLE)
      taken_r <= '0;
    else if (state_r == ST_CONV && conv_done_i)
      taken_r <= taken_r + CNT_W'(1);
  end

  // Trigger pulse to the converter core
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      conv_trigger_o <= 1'b0;
    else
      conv_trigger_o <= (state_r == ST_TRIG);
  end

  // Per-channel accumulate and average
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      logic signed [SAMPLE_W-1:0] sample; // Incoming channel word
      logic signed [ACC_W-1:0] sample_ext; // Sign-extended word
      logic signed [ACC_W-1:0] avg; // Shifted sum

      assign sample = conv_data_i[ch*SAMPLE_W +: SAMPLE_W];
      assign sample_ext = ACC_W'(sample);
      assign avg = acc_r[ch] >>> shift_r;

      // Running sum, restarted by the first sample
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          acc_r[ch] <= '0;
        else if (state_r == ST_CONV && conv_done_i)
        begin
          if (taken_r == '0)
            acc_r[ch] <= sample_ext;
          else
            acc_r[ch] <= acc_r[ch] + sample_ext;
        end
      end

      // Decimated result word
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          result_o[ch*SAMPLE_W +: SAMPLE_W] <= '0;
        else if (state_r == ST_DONE)
          result_o[ch*SAMPLE_W +: SAMPLE_W] <= avg[SAMPLE_W-1:0];
      end
    end
  endgenerate

  // Result strobe, one per burst
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      result_valid_o <= 1'b0;
    else
      result_valid_o <= (state_r == ST_DONE);
  end

  assign busy_o = (state_r != ST_IDLE);

  // Bus decode
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = bus_req & wb_we_i;
  assign rd_fresh_clr = bus_req & ~wb_we_i &
                        (wb_adr_i >= RESULT_BASE_OFS) & (wb_adr_i <= RESULT_LAST_OFS);
  // Word index counted from the result base, not from address zero
  assign res_word = 3'((wb_adr_i - RESULT_BASE_OFS) >> 2);

  // Control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable_r <= CTRL_ENABLE_RESET;
      soft_start_r <= 1'b0;
    end
    else
    begin
      soft_start_r <= 1'b0;
      if (wr_en && wb_adr_i == CTRL_OFS && wb_sel_i[0])
      begin
        enable_r <= wb_dat_i[CTRL_ENABLE_BIT];
        soft_start_r <= wb_dat_i[CTRL_SOFT_START_BIT];
      end
    end
  end

  // Overrun flag: start while busy; set wins over write-one-to-clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      overrun_r <= 1'b0;
    else if (busy_o && (start_edge || soft_start_r))
      overrun_r <= 1'b1;
    else if (wr_en && wb_adr_i == STATUS_OFS && wb_sel_i[0] && wb_dat_i[STAT_OVERRUN_BIT])
      overrun_r <= 1'b0;
  end

  // Fresh flag: set by new results, cleared by reading one; set wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fresh_r <= 1'b0;
    else if (state_r == ST_DONE)
      fresh_r <= 1'b1;
    else if (rd_fresh_clr)
      fresh_r <= 1'b0;
  end

  // Completed burst counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bursts_r <= '0;
    else if (state_r == ST_DONE)
      bursts_r <= bursts_r + 16'h0001;
  end

  // Read mux
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (wb_adr_i == CTRL_OFS)
      rd_data[CTRL_ENABLE_BIT] = enable_r;
    else if (wb_adr_i == STATUS_OFS)
    begin
      rd_data[STAT_BUSY_BIT] = busy_o;
      rd_data[STAT_INVALID_BIT] = (ratio_pin == RATIO_INVALID);
      rd_data[STAT_SPAN_BIT] = span_10v_o;
      rd_data[STAT_OVERRUN_BIT] = overrun_r;
      rd_data[STAT_FRESH_BIT] = fresh_r;
      rd_data[STAT_RATIO_LSB +: 3] = ratio_pin;
    end
    else if (wb_adr_i == BURSTS_OFS)
      rd_data[15:0] = bursts_r;
    else if (rd_fresh_clr)
      // Result word, sign-extended to the bus width
      rd_data = 32'(signed'(result_o[res_word * SAMPLE_W +: SAMPLE_W]));
  end

  // Bus answer, one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
        wb_dat_o <= rd_data;
    end
  end

endmodule // oaf_filter

`default_nettype wire

/* testbench/oaf_filter_asserts.sv */
// Port checks for the oversampling average filter
`timescale 1ns/10ps
`default_nettype none

module oaf_filter_asserts
  import oaf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus answer
  input wire logic wb_ack_o,
  // Burst outputs
  input wire logic conv_trigger_o,
  input wire logic [NUM_CH*SAMPLE_W-1:0] result_o,
  input wire logic result_valid_o,
  input wire logic busy_o
);
  // One clock domain
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_trig_after_busy: assert property ($rose(busy_o) |-> ##[0:2] conv_trigger_o)
    else $error("no first trigger");
  a_trig_in_burst: assert property (conv_trigger_o |-> busy_o)
    else $error("trigger while idle");
  a_trig_spaced: assert property (conv_trigger_o |=> !conv_trigger_o [*8])
    else $error("triggers too close");
  a_valid_single: assert property (result_valid_o |=> !result_valid_o)
    else $error("valid too long");
  a_valid_idle: assert property (result_valid_o |-> !busy_o)
    else $error("valid while busy");
  a_result_held: assert property (!result_valid_o |-> $stable(result_o))
    else $error("result moved");
  a_end_gives_word: assert property ($fell(busy_o) |-> result_valid_o)
    else $error("burst ended without word");
endmodule // oaf_filter_asserts

bind oaf_filter oaf_filter_asserts u_chk
(
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_ack_o(wb_ack_o),
  .conv_trigger_o(conv_trigger_o),
  .result_o(result_o),
  .result_valid_o(result_valid_o),
  .busy_o(busy_o)
);

`default_nettype wire

/* testbench/oaf_core_model.sv */
// Converter core model: answers each trigger after a set delay
`timescale 1ns/10ps
`default_nettype none

module oaf_core_model
  import oaf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Answer delay and burst handshake
  input wire logic [7:0] dly_i,
  input wire logic conv_trigger_i,
  input wire logic busy_i,
  output logic conv_done_o,
  output logic [NUM_CH*SAMPLE_W-1:0] conv_data_o
);
  logic [7:0] wait_r; // Cycles left to answer
  logic pend_r; // Conversion running
  int k_r; // Sample index in burst

  // Data toggles when not valid so stale words never match
  always_ff @(posedge clk_i)
  begin
    conv_done_o <= 1'b0;
    if (rst_i)
    begin
      pend_r <= 1'b0;
      k_r <= 0;
      conv_data_o <= '0;
    end
    else if (pend_r && wait_r == 8'h00)
    begin
      pend_r <= 1'b0;
      conv_done_o <= 1'b1;
      k_r <= k_r + 1;
      for (int n = 0; n < NUM_CH; n++)
        conv_data_o[n*SAMPLE_W+:SAMPLE_W] <= 16'(n * 1000 - 3500 + k_r);
    end
    else
    begin
      conv_data_o <= ~conv_data_o;
      wait_r <= wait_r - 8'h01;
      if (conv_trigger_i)
      begin
        pend_r <= 1'b1;
        wait_r <= dly_i;
      end
      if (!busy_i)
        k_r <= 0;
    end
  end
endmodule // oaf_core_model

`default_nettype wire

/* testbench/test_oaf_filter.sv */
// Bench for the oversampling average filter
`timescale 1ns/10ps
`default_nettype none

module test_oaf_filter;
  import oaf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00, dly = 8'h01;
  logic [31:0] wdat = 32'h0, rdat, dat_o, ev;
  logic sa = 1'b0, sb = 1'b0, span = 1'b0, trig, done, valid, busy, span_o;
  logic [2:0] ratio = 3'h0;
  logic [127:0] cdata, res, res_o;
  int failures = 0, compares = 0, ntrig = 0, i, e, nr;

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (trig === 1'b1) ntrig++;

  oaf_filter dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .sample_start_a_i(sa), .sample_start_b_i(sb),
    .average_ratio_select_i(ratio), .span_select_i(span), .conv_trigger_o(trig),
    .conv_done_i(done), .conv_data_i(cdata), .span_10v_o(span_o), .result_o(res_o),
    .result_valid_o(valid), .busy_o(busy));
  oaf_core_model core (.clk_i(clk_i), .rst_i(rst_i), .dly_i(dly), .conv_trigger_i(trig),
    .busy_i(busy), .conv_done_o(done), .conv_data_o(cdata));

  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Wishbone classic cycle, held until ack
  task wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (ack !== 1'b1 && i < 50);
    if (i == 50) failures++;
    rdat = dat_o;
    {cyc, stb} <= 2'b00;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    wbx(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  // Wait for the result strobe; a missing one counts as a failure
  task wait_valid;
    i = 0;
    while (valid !== 1'b1 && i < 45000)
    begin
      @(posedge clk_i);
      i++;
    end
    if (i == 45000)
      failures++;
  endtask

  // Start pins high then low
  task pins;
    {sa, sb} <= 2'b11;
    repeat (10) @(posedge clk_i);
    {sa, sb} <= 2'b00;
  endtask

  task tally_and_finish;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (95000) @(posedge clk_i);
    failures++;
    tally_and_finish;
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTRL_OFS, 32'h1);
    rd(8'h40, 32'h0);
    wbx(1'b1, CTRL_OFS, 32'h0);
    pins;
    repeat (20) @(posedge clk_i);
    chk(ntrig, 0);
    wbx(1'b1, CTRL_OFS, 32'h1);
    for (int c = 0; c < 8; c++)
    begin
      ratio <= 3'(c);
      span <= c[0];
      dly <= c[1] ? 8'hc8 : 8'h01;
      repeat (8) @(posedge clk_i);
      chk(span_o, c[0]);
      ntrig = 0;
      nr = (c == 7) ? 1 : (1 << c);
      pins;
      if (nr > 1)
      begin
        repeat (20) @(posedge clk_i);
        chk(busy, 1'b1);
        pins;
      end
      wait_valid;
      res = res_o;
      chk(ntrig, nr);
      rd(STATUS_OFS, {21'h0, 3'(c), 3'h0, 1'b1, nr > 1, c[0], c == 7, 1'b0});
      wbx(1'b1, STATUS_OFS, 32'h8);
      for (int n = 0; n < NUM_CH; n++)
      begin
        e = n * 1000 - 3500 + ((nr > 1) ? nr / 2 - 1 : 0);
        ev = e;
        chk({16'h0, res[n*16+:16]}, {16'h0, ev[15:0]});
        rd(RESULT_BASE_OFS + 8'(4 * n), ev);
      end
    end
    rd(BURSTS_OFS, 32'h8);
    rd(STATUS_OFS, 32'h0000_0706);
    // Software start: one more single-sample burst
    ntrig = 0;
    wbx(1'b1, CTRL_OFS, 32'h3);
    wait_valid;
    chk(ntrig, 1);
    chk({16'h0, res_o[15:0]}, 32'h0000_f254);
    rd(CTRL_OFS, 32'h1);
    rd(BURSTS_OFS, 32'h9);
    tally_and_finish;
  end
endmodule // test_oaf_filter

`default_nettype wire
